/* src/crx_consts.vh */
/*
 * crx_consts.vh: offsets, fields, reset values and opcodes of the
 * return and misc instruction unit.
 * assumes: included by the unit and its bench; byte addresses on a 32-bit bus.
 */
`ifndef CRX_CONSTS_VH
`define CRX_CONSTS_VH

// ============================================================
// register byte offsets, and the file window select on address bits 11:9
`define CRX_OFF_INSTR   12'h000
`define CRX_OFF_ACC     12'h004
`define CRX_OFF_STATUS  12'h008
`define CRX_OFF_PC      12'h00c
`define CRX_OFF_PTR0    12'h010
`define CRX_OFF_PTR1    12'h014
`define CRX_OFF_OPTION  12'h018
`define CRX_OFF_INTCTL  12'h01c
`define CRX_OFF_PWRCTL  12'h020
`define CRX_OFF_STACK   12'h024
`define CRX_OFF_CORE    12'h028
`define CRX_OFF_FILE    3'h1

// ============================================================
// instruction word fields
`define CRX_OP_LSB      0
`define CRX_OP_MSB      3
`define CRX_D_BIT       4
`define CRX_N_BIT       5
`define CRX_MM_LSB      6
`define CRX_MM_MSB      7
`define CRX_F_LSB       8
`define CRX_F_MSB       14
`define CRX_K_LSB       16
`define CRX_K_MSB       23

// ============================================================
// opcodes
`define CRX_NOP         4'h0
`define CRX_OPTION      4'h1
`define CRX_RESET       4'h2
`define CRX_RETURN_FROM_IRQ_INSTR      4'h3
`define CRX_RETURN      4'h4
`define CRX_RETURN_WITH_LITERAL_INSTR       4'h5
`define CRX_RLF         4'h6
`define CRX_MOVIW       4'h7
`define CRX_MOVWI       4'h8

// ============================================================
// status, interrupt and power bits
`define CRX_C_BIT       0
`define CRX_DC_BIT      1
`define CRX_Z_BIT       2
`define CRX_GIE_BIT     7
`define CRX_RIN_BIT     2

// ============================================================
// reset values and counts
`define CRX_RST_ACC     8'h00
`define CRX_RST_STATUS  3'h0
`define CRX_RST_PC      15'h0000
`define CRX_RST_PTR     16'h0000
`define CRX_RST_OPTION  8'hff
`define CRX_RST_INTCTL  8'h00
`define CRX_RET_CYCLES  2

`endif

/* src/crx_core.v */
/*
 * crx_core.v: execution unit for the indirect move, no-op, option
 * load, software reset, the three returns and rotate-left, with an
 * ahb-lite register slave.
 * assumes: one ahb-lite master, single word transfers, hclk 250 mhz.
 */
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "crx_consts.vh"

module crx_core (
    // clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp
);

// ============================================================
// state
reg  [7:0]  acc_ff;
reg  [2:0]  status_ff;
reg  [14:0] pc_ff;
reg  [15:0] ptr0_ff;
reg  [15:0] ptr1_ff;
reg  [7:0]  option_ff;
reg  [7:0]  intctl_ff;
reg         reset_instr_flag_n_ff;
reg  [3:0]  sp_ff;
reg  [14:0] ret_pc_ff;
reg  [2:0]  fsm_ff;
reg         fetch_ok_ff;
reg  [15:0] cycles_ff;
reg  [23:0] instr_ff;
reg  [14:0] stack_ff [0:15];
reg  [7:0]  file_ff [0:127];
reg         wr_pend_ff;
reg         rd_pend_ff;
reg  [11:0] addr_ff;
reg  [31:0] hrdata_ff;
reg         hready_ff;

localparam ST_IDLE = 3'b001;
localparam ST_RET2 = 3'b010;
localparam ST_SPARE = 3'b100;

assign hrdata    = hrdata_ff;
assign hreadyout = hready_ff;
assign hresp     = 1'b0;

// ============================================================
// decode of an instruction written over the bus
wire        busy     = (fsm_ff != ST_IDLE);
wire        go       = wr_pend_ff && (addr_ff == `CRX_OFF_INSTR) && !busy;
wire [3:0]  op       = hwdata[`CRX_OP_MSB:`CRX_OP_LSB];
wire        dsel     = hwdata[`CRX_D_BIT];
wire        nsel     = hwdata[`CRX_N_BIT];
wire [1:0]  mm       = hwdata[`CRX_MM_MSB:`CRX_MM_LSB];
wire [6:0]  faddr    = hwdata[`CRX_F_MSB:`CRX_F_LSB];
wire [7:0]  lit      = hwdata[`CRX_K_MSB:`CRX_K_LSB];
wire [15:0] ptr      = nsel ? ptr1_ff : ptr0_ff;
wire [15:0] ptr_upd  = mm[0] ? ptr - 16'h0001 : ptr + 16'h0001;
wire [15:0] ptr_ea   = mm[1] ? ptr : ptr_upd;
wire [6:0]  rlf_idx  = (faddr == 7'h00) ? ptr0_ff[6:0] :
                       (faddr == 7'h01) ? ptr1_ff[6:0] : faddr;
wire [7:0]  rlf_val  = file_ff[rlf_idx];
wire [7:0]  rlf_res  = {rlf_val[6:0], status_ff[`CRX_C_BIT]};
wire [14:0] stk_top  = stack_ff[sp_ff - 4'h1];
wire        is_ret   = (op == `CRX_RETURN_FROM_IRQ_INSTR) || (op == `CRX_RETURN) ||
                       (op == `CRX_RETURN_WITH_LITERAL_INSTR);
wire        soft_rst = go && (op == `CRX_RESET);

// bus side file window and stack push
wire        bus_wr   = wr_pend_ff && !go;
wire        file_win = (addr_ff[11:9] == `CRX_OFF_FILE);
wire        push     = bus_wr && (addr_ff == `CRX_OFF_STACK) && !busy;

// ============================================================
// ahb-lite address and data phases
wire        acc_ok   = hsel && hready && htrans[1];

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend_ff <= 1'b0;
        rd_pend_ff <= 1'b0;
        addr_ff    <= 12'h000;
        hready_ff  <= 1'b1;
        hrdata_ff  <= 32'h00000000;
    end else begin
        wr_pend_ff <= acc_ok && hwrite;
        rd_pend_ff <= acc_ok && !hwrite;
        if (acc_ok) begin
            addr_ff <= haddr;
        end
        hready_ff <= !(acc_ok && !hwrite);
        if (rd_pend_ff) begin
            hrdata_ff <= rd_mux(addr_ff);
        end
    end
end

function [31:0] rd_mux;
    input [11:0] a;
    begin
        rd_mux = 32'h00000000;
        if (a[11:9] == `CRX_OFF_FILE) begin
            rd_mux = {24'h000000, file_ff[a[8:2]]};
        end else begin
            case (a)
                `CRX_OFF_INSTR:  rd_mux = {8'h00, instr_ff};
                `CRX_OFF_ACC:    rd_mux = {24'h000000, acc_ff};
                `CRX_OFF_STATUS: rd_mux = {29'h00000000, status_ff};
                `CRX_OFF_PC:     rd_mux = {17'h00000, pc_ff};
                `CRX_OFF_PTR0:   rd_mux = {16'h0000, ptr0_ff};
                `CRX_OFF_PTR1:   rd_mux = {16'h0000, ptr1_ff};
                `CRX_OFF_OPTION: rd_mux = {24'h000000, option_ff};
                `CRX_OFF_INTCTL: rd_mux = {24'h000000, intctl_ff};
                `CRX_OFF_PWRCTL: rd_mux = {29'h00000000, reset_instr_flag_n_ff, 2'h0};
                `CRX_OFF_STACK:  rd_mux = {17'h00000, stk_top};
                `CRX_OFF_CORE:   rd_mux = {cycles_ff, 8'h00, sp_ff, 2'h0,
                                           fetch_ok_ff, busy};
                default:         rd_mux = 32'h00000000;
            endcase
        end
    end
endfunction

// ============================================================
// storage arrays, no reset
always @(posedge hclk) begin
    if (go && (op == `CRX_RLF) && dsel) begin
        file_ff[rlf_idx] <= rlf_res;
    end else if (go && (op == `CRX_MOVWI)) begin
        file_ff[ptr_ea[6:0]] <= acc_ff;
    end else if (bus_wr && file_win) begin
        file_ff[addr_ff[8:2]] <= hwdata[7:0];
    end
    if (push) begin
        stack_ff[sp_ff] <= hwdata[14:0];
    end
end

// ============================================================
// core registers and instruction execution
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        acc_ff                <= `CRX_RST_ACC;
        status_ff             <= `CRX_RST_STATUS;
        pc_ff                 <= `CRX_RST_PC;
        ptr0_ff               <= `CRX_RST_PTR;
        ptr1_ff               <= `CRX_RST_PTR;
        option_ff             <= `CRX_RST_OPTION;
        intctl_ff             <= `CRX_RST_INTCTL;
        reset_instr_flag_n_ff <= 1'b1;
        sp_ff                 <= 4'h0;
        ret_pc_ff             <= `CRX_RST_PC;
        fsm_ff                <= ST_IDLE;
        fetch_ok_ff           <= 1'b0;
        cycles_ff             <= 16'h0000;
        instr_ff              <= 24'h000000;
    end else if (soft_rst) begin
        acc_ff                <= `CRX_RST_ACC;
        status_ff             <= `CRX_RST_STATUS;
        pc_ff                 <= `CRX_RST_PC;
        ptr0_ff               <= `CRX_RST_PTR;
        ptr1_ff               <= `CRX_RST_PTR;
        option_ff             <= `CRX_RST_OPTION;
        intctl_ff             <= `CRX_RST_INTCTL;
        reset_instr_flag_n_ff <= 1'b0;
        sp_ff                 <= 4'h0;
        ret_pc_ff             <= `CRX_RST_PC;
        fsm_ff                <= ST_IDLE;
        fetch_ok_ff           <= 1'b0;
        cycles_ff             <= 16'h0000;
        instr_ff              <= hwdata[23:0];
    end else begin
        case (fsm_ff)
            ST_IDLE: begin
                if (go) begin
                    instr_ff  <= hwdata[23:0];
                    cycles_ff <= cycles_ff + 16'h0001;
                    if (is_ret) begin
                        ret_pc_ff <= stk_top;
                        sp_ff     <= sp_ff - 4'h1;
                        fsm_ff    <= ST_RET2;
                    end else begin
                        pc_ff       <= pc_ff + 15'h0001;
                        fetch_ok_ff <= 1'b1;
                    end
                    case (op)
                        `CRX_OPTION: option_ff <= acc_ff;
                        `CRX_RETURN_FROM_IRQ_INSTR: intctl_ff[`CRX_GIE_BIT] <= 1'b1;
                        `CRX_RETURN_WITH_LITERAL_INSTR:  acc_ff <= lit;
                        `CRX_RLF: begin
                            status_ff[`CRX_C_BIT] <= rlf_val[7];
                            if (!dsel) begin
                                acc_ff <= rlf_res;
                            end
                        end
                        `CRX_MOVIW: begin
                            acc_ff <= file_ff[ptr_ea[6:0]];
                            if (nsel) begin
                                ptr1_ff <= ptr_upd;
                            end else begin
                                ptr0_ff <= ptr_upd;
                            end
                        end
                        `CRX_MOVWI: begin
                            if (nsel) begin
                                ptr1_ff <= ptr_upd;
                            end else begin
                                ptr0_ff <= ptr_upd;
                            end
                        end
                        default: begin
                        end
                    endcase
                end else if (bus_wr) begin
                    case (addr_ff)
                        `CRX_OFF_ACC:    acc_ff    <= hwdata[7:0];
                        `CRX_OFF_STATUS: status_ff <= hwdata[2:0];
                        `CRX_OFF_PTR0:   ptr0_ff   <= hwdata[15:0];
                        `CRX_OFF_PTR1:   ptr1_ff   <= hwdata[15:0];
                        `CRX_OFF_INTCTL: intctl_ff <= hwdata[7:0];
                        `CRX_OFF_PWRCTL: reset_instr_flag_n_ff <= hwdata[`CRX_RIN_BIT];
                        `CRX_OFF_STACK:  sp_ff     <= sp_ff + 4'h1;
                        default: begin
                        end
                    endcase
                end
            end
            ST_RET2: begin
                pc_ff       <= ret_pc_ff;
                fetch_ok_ff <= 1'b0;
                cycles_ff   <= cycles_ff + 16'h0001;
                fsm_ff      <= ST_IDLE;
            end
            default: begin
                fsm_ff <= ST_IDLE;
            end
        endcase
    end
end

endmodule // crx_core

/* verification/crx_core_asserts.sv */
/*
 * crx_core_asserts.sv: bus timing checker for crx_core.
 * assumes: bound to crx_core, hready tied to hreadyout, one master.
 */
`timescale 1ns/10ps
// ============================================================
// checker
module crx_core_asserts (
    // clock and reset
    input wire        hclk,
    input wire        hresetn,
    // ahb-lite
    input wire        hsel,
    input wire [11:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp
);
    wire rd_take = hsel && hready && htrans[1] && !hwrite;
    wire wr_take = hsel && hready && htrans[1] && hwrite;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_RESP_OKAY: assert property (hresp == 1'b0)
        else $error("response not okay");
    AST_READ_WAIT: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read wait not one cycle");
    AST_WRITE_NO_WAIT: assert property (wr_take |=> hreadyout)
        else $error("write inserted a wait");
    AST_WAIT_ONE: assert property (!hreadyout |=> hreadyout)
        else $error("wait longer than one cycle");
    AST_WAIT_CAUSE: assert property ($fell(hreadyout) |-> $past(rd_take))
        else $error("wait without a read");
    AST_RDATA_HOLD: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved without a read");
    AST_UNMAPPED_ZERO: assert property (rd_take && haddr >= 12'h02c && haddr < 12'h200
        |-> ##2 hrdata == 32'h0) else $error("unmapped read not zero");
    AST_NARROW_ZERO: assert property (rd_take && (haddr == 12'h004 || haddr == 12'h018)
        |-> ##2 hrdata[31:8] == 24'h0) else $error("narrow register upper bits set");
endmodule // crx_core_asserts

bind crx_core crx_core_asserts crx_core_asserts_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

/* verification/test_crx_core.sv */
/*
 * test_crx_core.sv: register-level bench for crx_core.
 * assumes: crx_consts.vh on the include path, checker bound separately.
 */
`timescale 1ns/10ps
`include "crx_consts.vh"
// ============================================================
// bench
module test_crx_core;
    localparam [31:0] all_bits = 32'hffffffff;
    reg         hclk;
    reg         hresetn;
    reg         hsel;
    reg  [11:0] haddr;
    reg  [1:0]  htrans;
    reg         hwrite;
    reg  [31:0] hwdata;
    wire [31:0] hrdata;
    wire        hreadyout;
    wire        hresp;
    integer     fail_count;
    integer     check_count;
    reg  [31:0] rd;
    reg  [31:0] cyc;

    crx_core crx_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

    // ============================================================
    // tasks
    task bus(input reg w, input reg [11:0] a, input reg [31:0] d);
        begin
            @(posedge hclk);
            hsel   <= 1'b1;
            haddr  <= a;
            hwrite <= w;
            htrans <= 2'h2;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            rd = hrdata;
        end
    endtask
    task wr(input reg [11:0] a, input reg [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rdchk(input string nm, input reg [11:0] a, input reg [31:0] m, input reg [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            check_count = check_count + 1;
            if ((rd & m) !== e) begin
                fail_count = fail_count + 1;
                $display("Error %s expected %h seen %h", nm, e, rd & m);
            end
        end
    endtask
    function [31:0] ins(input [3:0] op, input d, input n, input [1:0] mm,
                        input [6:0] f, input [7:0] k);
        ins = {8'h00, k, 1'b0, f, mm, n, d, op};
    endfunction
    task finish_test;
        begin
            if (fail_count == 0 && check_count > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask

    // ============================================================
    // clock, watchdog, tests
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial begin
        repeat (3000) @(posedge hclk);
        fail_count = fail_count + 1;
        finish_test;
    end
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 12'h0; htrans = 2'h0;
        hwrite = 1'b0; hwdata = 32'h0; fail_count = 0; check_count = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk("option", `CRX_OFF_OPTION, all_bits, 32'hff);
        rdchk("rst_flag", `CRX_OFF_PWRCTL, 32'h4, 32'h4);
        rdchk("unmapped", 12'h100, all_bits, 32'h0);
        wr(`CRX_OFF_INSTR, ins(`CRX_NOP, 0, 0, 0, 0, 0));
        rdchk("pc", `CRX_OFF_PC, all_bits, 32'h1);
        rdchk("status", `CRX_OFF_STATUS, all_bits, 32'h0);
        wr(`CRX_OFF_ACC, 32'h4f);
        wr(`CRX_OFF_INSTR, ins(`CRX_OPTION, 0, 0, 0, 0, 0));
        wr(`CRX_OFF_OPTION, 32'h11);
        rdchk("option", `CRX_OFF_OPTION, all_bits, 32'h4f);
        rdchk("status", `CRX_OFF_STATUS, all_bits, 32'h0);
        wr(12'h214, 32'he6);
        wr(`CRX_OFF_INSTR, ins(`CRX_RLF, 0, 0, 0, 7'h05, 0));
        rdchk("acc", `CRX_OFF_ACC, all_bits, 32'hcc);
        rdchk("status", `CRX_OFF_STATUS, all_bits, 32'h1);
        rdchk("file", 12'h214, all_bits, 32'he6);
        wr(`CRX_OFF_INSTR, ins(`CRX_RLF, 1, 0, 0, 7'h05, 0));
        rdchk("file", 12'h214, all_bits, 32'hcd);
        rdchk("acc", `CRX_OFF_ACC, all_bits, 32'hcc);
        wr(`CRX_OFF_STATUS, 32'h6);
        wr(`CRX_OFF_STACK, 32'h0123);
        wr(`CRX_OFF_INSTR, ins(`CRX_RETURN, 0, 0, 0, 0, 0));
        rdchk("pc", `CRX_OFF_PC, all_bits, 32'h123);
        rdchk("status", `CRX_OFF_STATUS, all_bits, 32'h6);
        rdchk("fetch", `CRX_OFF_CORE, 32'h3, 32'h0);
        wr(`CRX_OFF_STACK, 32'h00aa);
        wr(`CRX_OFF_INSTR, ins(`CRX_RETURN_WITH_LITERAL_INSTR, 0, 0, 0, 0, 8'h5a));
        rdchk("acc", `CRX_OFF_ACC, all_bits, 32'h5a);
        rdchk("pc", `CRX_OFF_PC, all_bits, 32'haa);
        wr(`CRX_OFF_INTCTL, 32'h0);
        wr(`CRX_OFF_STACK, 32'h7ff0);
        bus(1'b0, `CRX_OFF_CORE, 32'h0);
        cyc = rd;
        wr(`CRX_OFF_INSTR, ins(`CRX_RETURN_FROM_IRQ_INSTR, 0, 0, 0, 0, 0));
        rdchk("pc", `CRX_OFF_PC, all_bits, 32'h7ff0);
        rdchk("irq_en", `CRX_OFF_INTCTL, 32'h80, 32'h80);
        rdchk("cycles", `CRX_OFF_CORE, 32'hffff0000, {cyc[31:16] + 16'h2, 16'h0});
        wr(`CRX_OFF_PTR0, 32'hffff);
        wr(`CRX_OFF_ACC, 32'h3c);
        wr(`CRX_OFF_STATUS, 32'h7);
        wr(`CRX_OFF_INSTR, ins(`CRX_MOVWI, 0, 0, 2'b00, 0, 0));
        rdchk("ptr0", `CRX_OFF_PTR0, all_bits, 32'h0);
        rdchk("file", 12'h200, all_bits, 32'h3c);
        rdchk("status", `CRX_OFF_STATUS, all_bits, 32'h7);
        wr(`CRX_OFF_PTR1, 32'h0);
        wr(`CRX_OFF_ACC, 32'h0);
        wr(`CRX_OFF_INSTR, ins(`CRX_MOVIW, 0, 1, 2'b11, 0, 0));
        rdchk("acc", `CRX_OFF_ACC, all_bits, 32'h3c);
        rdchk("ptr1", `CRX_OFF_PTR1, all_bits, 32'hffff);
        rdchk("ptr0", `CRX_OFF_PTR0, all_bits, 32'h0);
        wr(`CRX_OFF_PTR0, 32'h5);
        wr(`CRX_OFF_ACC, 32'h77);
        wr(`CRX_OFF_INSTR, ins(`CRX_MOVWI, 0, 0, 2'b01, 0, 0));
        rdchk("file", 12'h210, all_bits, 32'h77);
        rdchk("ptr0", `CRX_OFF_PTR0, all_bits, 32'h4);
        wr(`CRX_OFF_ACC, 32'h0);
        wr(`CRX_OFF_INSTR, ins(`CRX_MOVIW, 0, 0, 2'b10, 0, 0));
        rdchk("acc", `CRX_OFF_ACC, all_bits, 32'h77);
        rdchk("ptr0", `CRX_OFF_PTR0, all_bits, 32'h5);
        wr(`CRX_OFF_INSTR, ins(`CRX_RLF, 1, 0, 0, 7'h00, 0));
        rdchk("file", 12'h214, all_bits, 32'h9b);
        wr(`CRX_OFF_ACC, 32'h77);
        rdchk("unmapped", 12'h100, all_bits, 32'h0);
        wr(`CRX_OFF_INSTR, ins(`CRX_RESET, 0, 0, 0, 0, 0));
        rdchk("acc", `CRX_OFF_ACC, all_bits, 32'h0);
        rdchk("pc", `CRX_OFF_PC, all_bits, 32'h0);
        rdchk("option", `CRX_OFF_OPTION, all_bits, 32'hff);
        rdchk("rst_flag", `CRX_OFF_PWRCTL, 32'h4, 32'h0);
        finish_test;
    end
endmodule // test_crx_core
